/* File: gcr_host.sv */
// host model sending 24-bit serial register frames
`timescale 1ns/1ps
`default_nettype none
module gcr_host (
	input  wire logic clk,      // system clock
	output logic      spi_sclk, // serial clock, idle low
	output logic      spi_cs_n, // frame select
	output logic      spi_sdi,  // data to device
	input  wire logic spi_sdo   // data from device
);
	initial begin
		spi_sclk = 1'b0;
		spi_cs_n = 1'b1;
		spi_sdi  = 1'b1;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	// one frame msb first, five clocks per half bit, sdo taken at the end of the high phase of each of the sixteen data bits
	task automatic xfer(input logic rd, input logic [6:0] a, input logic [15:0] wd, output logic [15:0] rdat);
		logic [23:0] f;
		f = {rd, a, wd};
		rdat = 16'h0000;
		spi_cs_n = 1'b0;
		for (int i = 23; i >= 0; i--) begin
			spi_sdi = f[i];
			tick(5);
			spi_sclk = 1'b1;
			tick(5);
			if (i < 16) rdat[i] = spi_sdo;
			spi_sclk = 1'b0;
		end
		tick(5);
		spi_cs_n = 1'b1;
		spi_sdi  = ~f[0]; // inverse of the last bit, no stale bit
		tick(6);
	endtask : xfer
endmodule : gcr_host
`default_nettype wire

/* File: gcr_pkg.sv */
// constants for the pin and converter clear-value register block
package gcr_pkg;
	// register address width and data width of the serial frame, clear-code width, pin and channel counts
	localparam int unsigned ADDR_W   = 7;
	localparam int unsigned DATA_W   = 16;
	localparam int unsigned CODE_W   = 10;
	localparam int unsigned PIN_N    = 12;
	localparam int unsigned CH_N     = 4;

	// register offsets
	localparam logic [6:0] OFS_CLEAR_CH0  = 7'h2f;
	localparam logic [6:0] OFS_CLEAR_CH1  = 7'h30;
	localparam logic [6:0] OFS_CLEAR_CH2  = 7'h31;
	localparam logic [6:0] OFS_CLEAR_CH3  = 7'h32;
	localparam logic [6:0] OFS_PIN_DIR    = 7'h33;
	localparam logic [6:0] OFS_PIN_OUT    = 7'h34;
	localparam logic [6:0] OFS_PIN_IN     = 7'h35;

	// field positions
	localparam int unsigned CODE_MSB     = 9;
	localparam int unsigned PIN_MSB      = 11;
	localparam int unsigned GRP_A_LSB    = 0;
	localparam int unsigned GRP_B_LSB    = 4;
	localparam int unsigned GRP_C_LSB    = 8;

	// reset values
	localparam logic [9:0]  RST_CLEAR_CODE = 10'h000;
	localparam logic [11:0] RST_PIN_DIR    = 12'h000;
	localparam logic [11:0] RST_PIN_OUT    = 12'h000;

	// serial frame: read flag, address, data, msb first
	localparam logic [4:0] FRAME_BITS    = 5'd24;
	localparam logic [4:0] CMD_BITS      = 5'd8;
	localparam int unsigned CMD_RW_BIT   = 7;
	localparam logic [4:0] BITCNT_ZERO   = 5'd0;
	localparam logic [4:0] BITCNT_ONE    = 5'd1;

	// frame phases
	typedef enum logic [1:0] {
		GCR_IDLE = 2'b00,
		GCR_CMD  = 2'b01,
		GCR_DATA = 2'b10,
		GCR_DONE = 2'b11
	} gcr_phase_e;
endpackage : gcr_pkg

/* File: gcr_regs.sv */
// serial register slave with twelve pins and four converter clear codes
`timescale 1ns/1ps
`default_nettype none
module gcr_regs
	import gcr_pkg::*;
(
	input  wire logic                      clk,             // system clock, 20 MHz
	input  wire logic                      sys_rst,         // synchronous reset, active high
	input  wire logic                      spi_sclk,        // serial clock from host
	input  wire logic                      spi_cs_n,        // frame select, active low
	input  wire logic                      spi_sdi,         // serial data from host
	output logic                           spi_sdo,         // serial data to host
	output logic                           spi_sdo_oe,      // sdo driven while selected
	input  wire logic [gcr_pkg::PIN_N-1:0] pin_in,          // pin levels from pads
	output logic      [gcr_pkg::PIN_N-1:0] pin_out,         // pin drive levels
	output logic      [gcr_pkg::PIN_N-1:0] pin_oe,          // pin drive enables
	output logic      [gcr_pkg::CODE_W-1:0] clear_code_ch0, // clear code channel 0
	output logic      [gcr_pkg::CODE_W-1:0] clear_code_ch1, // clear code channel 1
	output logic      [gcr_pkg::CODE_W-1:0] clear_code_ch2, // clear code channel 2
	output logic      [gcr_pkg::CODE_W-1:0] clear_code_ch3  // clear code channel 3
);
	import gcr_pkg::*;

	// synchroniser stages for serial pins
	logic [2:0]           sclk_s_r;
	logic [2:0]           csn_s_r;
	logic [2:0]           sdi_s_r;
	logic                 sclk_f_r;
	logic                 csn_f_r;
	logic                 sdi_f_r;
	logic                 sclk_prev_r;
	// synchroniser stages for pins
	logic [PIN_N-1:0]     pin_s1_r;
	logic [PIN_N-1:0]     pin_s2_r;
	logic [PIN_N-1:0]     pin_s3_r;
	logic [PIN_N-1:0]     pin_f_r;
	// frame state
	gcr_phase_e           phase_r;
	gcr_phase_e           phase_nxt;
	logic [4:0]           bit_cnt_r;
	logic [DATA_W-1:0]    shift_in_r;
	logic [DATA_W-1:0]    shift_out_r;
	logic                 rd_flag_r;
	logic [ADDR_W-1:0]    addr_r;
	logic                 sdo_r;
	// register contents
	logic [CODE_W-1:0]    clear_code_r [CH_N];
	logic [PIN_N-1:0]     pin_dir_r;
	logic [PIN_N-1:0]     pin_val_r;
	logic [PIN_N-1:0]     pin_drv_r;
	// derived strobes
	logic                 sclk_rise;
	logic                 sclk_fall;
	logic                 selected;
	logic                 cmd_done;
	logic                 frame_done;
	logic                 wr_commit;
	logic [DATA_W-1:0]    wr_word;
	logic [DATA_W-1:0]    rd_word;
	logic [PIN_N-1:0]     pin_readback;
	logic [ADDR_W-1:0]    cmd_addr;

	// three-stage synchronisers, only stage two reads stage one
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sclk_s_r <= 3'h0;
			csn_s_r  <= 3'h7;
			sdi_s_r  <= 3'h0;
		end else begin
			sclk_s_r <= {sclk_s_r[1:0], spi_sclk};
			csn_s_r  <= {csn_s_r[1:0], spi_cs_n};
			sdi_s_r  <= {sdi_s_r[1:0], spi_sdi};
		end
	end

	// filtered serial levels, updated when stages two and three agree
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sclk_f_r    <= 1'b0;
			csn_f_r     <= 1'b1;
			sdi_f_r     <= 1'b0;
			sclk_prev_r <= 1'b0;
		end else begin
			if (sclk_s_r[1] == sclk_s_r[2]) begin
				sclk_f_r <= sclk_s_r[2];
			end
			if (csn_s_r[1] == csn_s_r[2]) begin
				csn_f_r <= csn_s_r[2];
			end
			if (sdi_s_r[1] == sdi_s_r[2]) begin
				sdi_f_r <= sdi_s_r[2];
			end
			sclk_prev_r <= sclk_f_r;
		end
	end

	// pin input synchronisers and agreement filter
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pin_s1_r <= 12'h000;
			pin_s2_r <= 12'h000;
			pin_s3_r <= 12'h000;
			pin_f_r  <= 12'h000;
		end else begin
			pin_s1_r <= pin_in;
			pin_s2_r <= pin_s1_r;
			pin_s3_r <= pin_s2_r;
			pin_f_r  <= (pin_s2_r & pin_s3_r) | (pin_f_r & (pin_s2_r ^ pin_s3_r));
		end
	end

	// edge strobes of the filtered serial clock
	assign selected   = ~csn_f_r;
	assign sclk_rise  = selected & sclk_f_r & ~sclk_prev_r;
	assign sclk_fall  = selected & ~sclk_f_r & sclk_prev_r;
	assign cmd_done   = sclk_rise && (bit_cnt_r == (CMD_BITS - BITCNT_ONE));
	assign frame_done = sclk_rise && (bit_cnt_r == (FRAME_BITS - BITCNT_ONE));
	assign wr_word    = {shift_in_r[DATA_W-2:0], sdi_f_r};
	assign wr_commit  = frame_done & ~rd_flag_r;
	assign cmd_addr   = {shift_in_r[ADDR_W-2:0], sdi_f_r};

	// frame phase sequencing
	always_comb begin
		phase_nxt = phase_r;
		case (phase_r)
			GCR_IDLE: begin
				if (selected) begin
					phase_nxt = GCR_CMD;
				end
			end
			GCR_CMD: begin
				if (cmd_done) begin
					phase_nxt = GCR_DATA;
				end
			end
			GCR_DATA: begin
				if (frame_done) begin
					phase_nxt = GCR_DONE;
				end
			end
			GCR_DONE: begin
				phase_nxt = GCR_DONE;
			end
			default: begin
				phase_nxt = GCR_IDLE;
			end
		endcase
		if (!selected) begin
			phase_nxt = GCR_IDLE;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			phase_r <= GCR_IDLE;
		end else begin
			phase_r <= phase_nxt;
		end
	end

	// bit counter and input shifter
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			bit_cnt_r  <= BITCNT_ZERO;
			shift_in_r <= 16'h0000;
		end else if (!selected) begin
			bit_cnt_r  <= BITCNT_ZERO;
		end else if (sclk_rise && (phase_r != GCR_DONE)) begin
			bit_cnt_r  <= bit_cnt_r + BITCNT_ONE;
			shift_in_r <= wr_word;
		end
	end

	// command capture at the eighth bit
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rd_flag_r <= 1'b0;
			addr_r    <= 7'h00;
		end else if (cmd_done && (phase_r == GCR_CMD)) begin
			rd_flag_r <= shift_in_r[CMD_RW_BIT-1];
			addr_r    <= cmd_addr;
		end
	end

	// readback of the pin input register
	assign pin_readback = (pin_dir_r & pin_val_r) | (~pin_dir_r & pin_f_r);

	// read data multiplexer, unmapped offsets read zero
	always_comb begin
		rd_word = 16'h0000;
		case (cmd_addr)
			OFS_CLEAR_CH0: rd_word = {6'h00, clear_code_r[0]};
			OFS_CLEAR_CH1: rd_word = {6'h00, clear_code_r[1]};
			OFS_CLEAR_CH2: rd_word = {6'h00, clear_code_r[2]};
			OFS_CLEAR_CH3: rd_word = {6'h00, clear_code_r[3]};
			OFS_PIN_DIR:   rd_word = {4'h0, pin_dir_r};
			OFS_PIN_OUT:   rd_word = {4'h0, pin_val_r};
			OFS_PIN_IN:    rd_word = {4'h0, pin_readback};
			default:       rd_word = 16'h0000;
		endcase
	end

	// output shifter, loaded at command end and shifted on falling edges
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			shift_out_r <= 16'h0000;
			sdo_r       <= 1'b0;
		end else if (!selected) begin
			sdo_r       <= 1'b0;
		end else if (cmd_done && (phase_r == GCR_CMD)) begin
			shift_out_r <= shift_in_r[CMD_RW_BIT-1] ? rd_word : 16'h0000;
		end else if (sclk_fall && (phase_r == GCR_DATA)) begin
			sdo_r       <= shift_out_r[DATA_W-1];
			shift_out_r <= {shift_out_r[DATA_W-2:0], 1'b0};
		end
	end

	// clear-code registers, one per channel
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			for (int i = 0; i < CH_N; i++) begin
				clear_code_r[i] <= RST_CLEAR_CODE;
			end
		end else if (wr_commit && (phase_r == GCR_DATA)) begin
			case (addr_r)
				OFS_CLEAR_CH0: clear_code_r[0] <= wr_word[CODE_MSB:0];
				OFS_CLEAR_CH1: clear_code_r[1] <= wr_word[CODE_MSB:0];
				OFS_CLEAR_CH2: clear_code_r[2] <= wr_word[CODE_MSB:0];
				OFS_CLEAR_CH3: clear_code_r[3] <= wr_word[CODE_MSB:0];
				OFS_PIN_IN: begin
					// read-only offset, the written word is dropped
				end
				default: begin
				end
			endcase
		end
	end

	// direction register, writes to the input register leave it unchanged
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pin_dir_r <= RST_PIN_DIR;
		end else if (wr_commit && (phase_r == GCR_DATA) && (addr_r == OFS_PIN_DIR)) begin
			pin_dir_r <= wr_word[PIN_MSB:0];
		end
	end

	// output-value register, writable whatever the direction
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pin_val_r <= RST_PIN_OUT;
		end else if (wr_commit && (phase_r == GCR_DATA) && (addr_r == OFS_PIN_OUT)) begin
			pin_val_r <= wr_word[PIN_MSB:0];
		end
	end

	// registered pad level, updated in the same cycle as the register it follows,
	// so a pin never carries a drive level while its enable is low
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pin_drv_r <= RST_PIN_OUT & RST_PIN_DIR;
		end else if (wr_commit && (phase_r == GCR_DATA) && (addr_r == OFS_PIN_DIR)) begin
			pin_drv_r <= pin_val_r & wr_word[PIN_MSB:0];
		end else if (wr_commit && (phase_r == GCR_DATA) && (addr_r == OFS_PIN_OUT)) begin
			pin_drv_r <= wr_word[PIN_MSB:0] & pin_dir_r;
		end
	end

	// pad level from the drive register
	assign pin_out = pin_drv_r;

	// group views of the pins for the three banks, joined into the pad enables
	logic [3:0] grp_a_dir;
	logic [3:0] grp_b_dir;
	logic [3:0] grp_c_dir;
	assign grp_a_dir = pin_dir_r[GRP_A_LSB +: 4];
	assign grp_b_dir = pin_dir_r[GRP_B_LSB +: 4];
	assign grp_c_dir = pin_dir_r[GRP_C_LSB +: 4];
	assign pin_oe    = {grp_c_dir, grp_b_dir, grp_a_dir};

	// serial output and clear codes
	assign spi_sdo        = sdo_r;
	assign spi_sdo_oe     = selected;
	assign clear_code_ch0 = clear_code_r[0];
	assign clear_code_ch1 = clear_code_r[1];
	assign clear_code_ch2 = clear_code_r[2];
	assign clear_code_ch3 = clear_code_r[3];
endmodule : gcr_regs
`default_nettype wire

/* File: gcr_regs_bench.sv */
// self-checking bench for the pin and clear-code registers
`timescale 1ns/1ps
`default_nettype none
module gcr_regs_bench;
	import gcr_pkg::*;
	logic        clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        spi_sclk, spi_cs_n, spi_sdi, spi_sdo, spi_sdo_oe;
	logic [11:0] pin_in = 12'h000;
	logic [11:0] pin_out, pin_oe;
	logic [9:0]  cc [0:3];
	logic [15:0] d, o;
	int          num_errors = 0;
	int          n_compared = 0;
	int          cyc = 0;
	always #25 clk = ~clk;
	gcr_regs dut (.clk(clk), .sys_rst(sys_rst), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi),
		.spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
		.clear_code_ch0(cc[0]), .clear_code_ch1(cc[1]), .clear_code_ch2(cc[2]), .clear_code_ch3(cc[3]));
	gcr_host host (.clk(clk), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo));
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic rd(input logic [6:0] a, input logic [15:0] exp);
		logic [15:0] v;
		host.xfer(1'b1, a, 16'h0000, v);
		check(v, exp);
	endtask : rd
	task automatic wr(input logic [6:0] a, input logic [15:0] v);
		logic [15:0] x;
		host.xfer(1'b0, a, v, x);
	endtask : wr
	// readback: output pins echo their value, input pins their level
	function automatic logic [15:0] pin_rb(input logic [15:0] dir, out, input logic [11:0] pin);
		return {4'h0, (dir[11:0] & out[11:0]) | (~dir[11:0] & pin)};
	endfunction : pin_rb
	task automatic wrap_up;
		$display("counts: %0d compared, %0d bad", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : wrap_up
	// cycle ceiling against a hang
	always @(posedge clk) begin
		cyc++;
		if (cyc == 30000) begin
			num_errors++;
			wrap_up();
		end
	end
	initial begin
		void'($urandom(47));
		host.tick(5);
		sys_rst = 1'b0;
		host.tick(4);
		check({4'h0, pin_oe}, 16'h0000);
		rd(OFS_PIN_DIR, 16'h0000);
		rd(OFS_PIN_OUT, 16'h0000);
		$display("test reset values done");
		for (int ch = 0; ch < 4; ch++) begin
			d = (ch == 0) ? 16'hffff : 16'($urandom);
			wr(OFS_CLEAR_CH0 + 7'(ch), d);
			check({6'h00, cc[ch]}, {6'h00, d[9:0]});
			rd(OFS_CLEAR_CH0 + 7'(ch), {6'h00, d[9:0]});
		end
		$display("test clear codes done");
		for (int k = 0; k < 6; k++) begin
			d = (k == 0) ? 16'hffff : (k == 1) ? 16'h0000 : 16'($urandom);
			o = (k < 2) ? 16'hffff : 16'($urandom);
			pin_in = 12'($urandom);
			wr(OFS_PIN_DIR, d);
			wr(OFS_PIN_OUT, o);
			check({4'h0, pin_oe}, {4'h0, d[11:0]});
			check({4'h0, pin_out}, {4'h0, d[11:0] & o[11:0]});
			rd(OFS_PIN_DIR, {4'h0, d[11:0]});
			rd(OFS_PIN_OUT, {4'h0, o[11:0]});
			rd(OFS_PIN_IN, pin_rb(d, o, pin_in));
		end
		$display("test pin direction and levels done");
		wr(OFS_PIN_IN, 16'hffff);
		rd(OFS_PIN_DIR, {4'h0, d[11:0]});
		rd(OFS_PIN_IN, pin_rb(d, o, pin_in));
		rd(7'h7f, 16'h0000);
		$display("test read-only and unmapped done");
		sys_rst = 1'b1;
		host.tick(5);
		sys_rst = 1'b0;
		host.tick(4);
		check({4'h0, pin_oe}, 16'h0000);
		rd(OFS_PIN_OUT, 16'h0000);
		check({4'h0, pin_out}, 16'h0000);
		check({6'h00, cc[0] | cc[1] | cc[2] | cc[3]}, 16'h0000);
		$display("test second reset done");
		wrap_up();
	end
endmodule : gcr_regs_bench
`default_nettype wire

/* File: gcr_regs_properties.sv */
// assertion checker for the pin and clear-code registers
`timescale 1ns/1ps
`default_nettype none
module gcr_regs_chk
	import gcr_pkg::*;
(
	input wire logic              clk,        // clock
	input wire logic              sys_rst,    // reset
	input wire logic              spi_cs_n,   // frame select
	input wire logic              spi_sdo,    // serial out
	input wire logic              spi_sdo_oe, // serial out enable
	input wire logic [PIN_N-1:0]  pin_oe,     // pin enables
	input wire logic [PIN_N-1:0]  pin_out,    // pin levels
	input wire logic [CODE_W-1:0] clear_code_ch0, // code 0
	input wire logic [CODE_W-1:0] clear_code_ch1, // code 1
	input wire logic [CODE_W-1:0] clear_code_ch2, // code 2
	input wire logic [CODE_W-1:0] clear_code_ch3  // code 3
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	// host quiet for some cycles
	sequence s_idle;
		spi_cs_n [*6];
	endsequence
	sequence s_reset;
		sys_rst ##1 1'b1;
	endsequence
	a_rst_dir_zero: assert property (disable iff (1'b0) s_reset |-> pin_oe == 12'h000)
		else $error("pin enables not cleared by reset");
	a_rst_out_zero: assert property (disable iff (1'b0) s_reset |-> pin_out == 12'h000)
		else $error("pin levels not cleared by reset");
	a_rst_code_zero: assert property (disable iff (1'b0)
		s_reset |-> (clear_code_ch0 | clear_code_ch1 | clear_code_ch2 | clear_code_ch3) == 10'h000)
		else $error("clear codes not cleared by reset");
	a_input_undriven: assert property ((pin_out & ~pin_oe) == 12'h000)
		else $error("input pin carries a drive level");
	a_dir_hold_idle: assert property (s_idle |-> $stable(pin_oe) && $stable(pin_out))
		else $error("pin state moved without a frame");
	a_code_hold_idle: assert property (s_idle |-> $stable({clear_code_ch0, clear_code_ch1, clear_code_ch2, clear_code_ch3}))
		else $error("clear code moved without a frame");
	a_sdo_idle_low: assert property (s_idle |-> !spi_sdo && !spi_sdo_oe)
		else $error("serial out active while deselected");
	a_oe_in_frame: assert property ($changed(pin_oe) |-> !spi_cs_n)
		else $error("pin enables changed outside a frame");
endmodule : gcr_regs_chk
bind gcr_regs gcr_regs_chk chk (.clk(clk), .sys_rst(sys_rst), .spi_cs_n(spi_cs_n), .spi_sdo(spi_sdo),
	.spi_sdo_oe(spi_sdo_oe), .pin_oe(pin_oe), .pin_out(pin_out), .clear_code_ch0(clear_code_ch0),
	.clear_code_ch1(clear_code_ch1), .clear_code_ch2(clear_code_ch2), .clear_code_ch3(clear_code_ch3));
`default_nettype wire
